// ### core/blr_pkg.sv
/*
 * blr_pkg: constants shared by the bus-loss reaction block and its
 * fault-code translator.
 * assumes: included before every other file of the block.
 */
package blr_pkg;

	// object dictionary indexes
	localparam logic [15:0] OD_IDX_BUS_LOSS_REACTION_SELECT = 16'h6007;
	localparam logic [15:0] OD_IDX_LAST_FAULT_CODE = 16'h603F;

	// reaction code limits and reset value (signed 16-bit)
	localparam logic signed [15:0] REACT_MIN = 16'shFFFE;
	localparam logic signed [15:0] REACT_MAX = 16'sh0003;
	localparam logic signed [15:0] REACT_RESET = 16'sh0001;

	// reaction codes
	localparam logic signed [15:0] REACT_NONE = 16'sh0000;
	localparam logic signed [15:0] REACT_FAULT = 16'sh0001;
	localparam logic signed [15:0] REACT_SWITCH_OFF = 16'sh0002;
	localparam logic signed [15:0] REACT_QUICK_STOP = 16'sh0003;
	localparam logic signed [15:0] REACT_RAMP_FAULT = 16'shFFFF;
	localparam logic signed [15:0] REACT_QSTOP_FAULT = 16'shFFFE;

	// internal bus error parameter: top of the direct range and the values above it
	localparam logic [2:0] PAR_MAX_DIRECT = 3'h3;
	localparam logic [2:0] PAR_RAMP_FAULT = 3'h4;
	localparam logic [2:0] PAR_QSTOP_FAULT = 3'h5;

	// control source selection: remote state machine
	localparam logic CTRL_SRC_REMOTE = 1'h1;

	// internal fault classes
	localparam logic [7:0] FCLS_NONE = 8'h00;
	localparam logic [7:0] FCLS_OVERLOAD = 8'h01;
	localparam logic [7:0] FCLS_CASE_TEMP = 8'h02;
	localparam logic [7:0] FCLS_INSIDE_TEMP = 8'h03;
	localparam logic [7:0] FCLS_MOTOR_TEMP = 8'h04;
	localparam logic [7:0] FCLS_OVERCURRENT = 8'h05;
	localparam logic [7:0] FCLS_DC_LINK = 8'h07;
	localparam logic [7:0] FCLS_ELEC_SUPPLY = 8'h08;
	localparam logic [7:0] FCLS_EARTH_FAULT = 8'h0D;

	// drive-profile fault codes
	localparam logic [15:0] PCODE_NONE = 16'h0000;
	localparam logic [15:0] PCODE_OVERLOAD = 16'h2310;
	localparam logic [15:0] PCODE_CASE_TEMP = 16'h4210;
	localparam logic [15:0] PCODE_INSIDE_TEMP = 16'h4110;
	localparam logic [15:0] PCODE_MOTOR_TEMP = 16'h4310;
	localparam logic [15:0] PCODE_OVERCURRENT = 16'h2340;
	localparam logic [15:0] PCODE_DC_LINK = 16'h3210;
	localparam logic [15:0] PCODE_ELEC_SUPPLY = 16'h5111;
	localparam logic [15:0] PCODE_EARTH_FAULT = 16'h2330;
	localparam logic [15:0] PCODE_GENERIC = 16'h1000;

	// emergency message field positions
	localparam int EMCY_PCODE_LSB = 0;
	localparam int EMCY_ICODE_LSB = 32;

	// reaction sequencer states
	typedef enum logic [1:0] {
		BLR_ST_IDLE,
		BLR_ST_STOPPING,
		BLR_ST_TRIPPED
	} blr_state_t;

endpackage : blr_pkg

// ### core/blr_fc_if.sv
/*
 * blr_fc_if: carries a fault class to the translator and the profile
 * code back.
 * assumes: both ends in the core_clk domain; the path is combinational.
 */
`timescale 1ns/100ps
interface blr_fc_if;
	logic [7:0] fault_class; // internal fault class
	logic [15:0] profile_code; // translated drive-profile code
	modport requester (output fault_class, input profile_code);
	modport translator (input fault_class, output profile_code);
endinterface : blr_fc_if

// ### core/blr_fault_xlate.sv
/*
 * blr_fault_xlate: maps internal fault classes onto drive-profile codes.
 * assumes: pure combinational lookup, sampled by the caller.
 */
`timescale 1ns/100ps
module blr_fault_xlate
	import blr_pkg::*;
(
	// class in, code out
	blr_fc_if.translator fc
);

	// fixed lookup; anything unlisted collapses onto the generic code
	always_comb begin
		case (fc.fault_class)
			FCLS_NONE: fc.profile_code = PCODE_NONE;
			FCLS_OVERLOAD: fc.profile_code = PCODE_OVERLOAD;
			FCLS_CASE_TEMP: fc.profile_code = PCODE_CASE_TEMP;
			FCLS_INSIDE_TEMP: fc.profile_code = PCODE_INSIDE_TEMP;
			FCLS_MOTOR_TEMP: fc.profile_code = PCODE_MOTOR_TEMP;
			FCLS_OVERCURRENT: fc.profile_code = PCODE_OVERCURRENT;
			FCLS_DC_LINK: fc.profile_code = PCODE_DC_LINK;
			FCLS_ELEC_SUPPLY: fc.profile_code = PCODE_ELEC_SUPPLY;
			FCLS_EARTH_FAULT: fc.profile_code = PCODE_EARTH_FAULT;
			default: fc.profile_code = PCODE_GENERIC;
		endcase
	end

endmodule : blr_fault_xlate

// ### core/blr_bus_loss_reaction.sv
/*
 * blr_bus_loss_reaction: picks the reaction to a fieldbus loss, keeps
 * the reaction code object and the last fault code object, and builds
 * the emergency message payload.
 * assumes: all inputs synchronous to core_clk; the drive state machine,
 * nonvolatile store and message transport live outside.
 */
// Notes on behaviour
// - any bus loss event triggers configured reaction
// - code 0: ignore faults, keep operating point
// - code 1 default: fault state immediately
// - codes 2/3: disable voltage or quick stop
// - codes -1/-2: stop, fault after standstill
// - reactions only under remote state machine control
// - signed 16-bit code limited to -2..3
// - internal parameter 0..5 mirrors the code
// - save stores code; power-up restores it
// - fault reset refused until NMT operational
// - fault reset refused until guarding restarted
// - discard RxPDO until correct length frame
// - read-only last fault profile code, 0 none
// - thermal and overload classes map to codes
// - current, voltage, earth map; others generic
// - internal code readable when generic reported
// - emergency: profile bytes 0-1, internal 4-7
// - control source 1 selects remote state machine
`timescale 1ns/100ps
module blr_bus_loss_reaction
	import blr_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// object dictionary access
	input wire logic od_req,
	input wire logic od_wr,
	input wire logic [15:0] od_index,
	input wire logic [15:0] od_wdata,
	output logic od_ack,
	output logic od_abort,
	output logic [15:0] od_rdata,
	// internal bus error parameter
	input wire logic par_wr,
	input wire logic [2:0] par_wdata,
	output logic par_reject,
	// nonvolatile store
	input wire logic save_req,
	input wire logic nv_valid,
	input wire logic [15:0] nv_code,
	output logic nv_wr,
	output logic [15:0] nv_wdata,
	// bus loss events
	input wire logic ev_bus_off,
	input wire logic ev_guard_fail,
	input wire logic ev_heartbeat_fail,
	input wire logic ev_sync_err,
	input wire logic ev_rxpdo_len_err,
	input wire logic ev_nmt_left_op,
	// link status
	input wire logic nmt_operational,
	input wire logic guarding_active,
	// drive state machine
	input wire logic control_source_setting,
	input wire logic drive_standstill,
	input wire logic fault_reset_req,
	output logic cmd_fault,
	output logic cmd_disable_voltage,
	output logic cmd_quick_stop,
	output logic cmd_disable_operation,
	output logic fault_reset_ok,
	// rxpdo gate
	input wire logic rxpdo_valid,
	input wire logic rxpdo_len_ok,
	output logic rxpdo_accept,
	output logic rxpdo_blocked,
	// fault reporting
	input wire logic fault_valid,
	input wire logic [7:0] fault_class,
	input wire logic [15:0] fault_code_int,
	output logic [15:0] current_error,
	output logic emcy_valid,
	output logic [63:0] emcy_data
);

	// range check used by the object write and restore paths that load the code
	function automatic logic code_in_range(input logic signed [15:0] c);
		code_in_range = (c >= REACT_MIN) && (c <= REACT_MAX);
	endfunction : code_in_range

	logic signed [15:0] react_code_reg; // bus_loss_reaction_select
	logic [15:0] last_fault_code_reg; // last_fault_code object
	logic [15:0] current_error_reg; // internal code of last fault
	logic save_pending_reg; // object written since last save
	logic restore_done_reg; // power-up restore taken
	logic nmt_lost_reg; // node left operational through a bus loss
	logic guard_lost_reg; // guarding failed, not restarted yet
	logic rxpdo_block_reg; // rxpdo discard in force
	blr_state_t state_reg; // reaction sequencer
	blr_state_t state_next;
	logic [3:0] cmd_next; // fault, disable volt, quick stop, disable op
	logic [3:0] cmd_reg;
	logic bus_loss; // any bus loss event this cycle
	logic remote_ctrl; // state machine control selected
	logic od_hit_react; // access targets reaction code
	logic od_hit_fault; // access targets fault code
	logic od_wr_ok; // accepted reaction code write
	logic signed [15:0] par_mapped; // parameter value as object code
	logic [15:0] pcode; // translated profile code

	// translator link
	blr_fc_if fc_link ();
	assign fc_link.fault_class = fault_class;
	assign pcode = fc_link.profile_code;
	blr_fault_xlate u_xlate (
		.fc(fc_link)
	);

	// event gathering and address decode
	assign bus_loss = ev_bus_off | ev_guard_fail | ev_heartbeat_fail
		| ev_sync_err | ev_rxpdo_len_err | ev_nmt_left_op;
	assign remote_ctrl = (control_source_setting == CTRL_SRC_REMOTE);
	assign od_hit_react = (od_index == OD_IDX_BUS_LOSS_REACTION_SELECT);
	assign od_hit_fault = (od_index == OD_IDX_LAST_FAULT_CODE);
	assign od_wr_ok = od_req && od_wr && od_hit_react
		&& code_in_range(od_wdata);

	// parameter 4 and 5 fold onto the negative codes
	always_comb begin
		case (par_wdata)
			PAR_RAMP_FAULT: par_mapped = REACT_RAMP_FAULT;
			PAR_QSTOP_FAULT: par_mapped = REACT_QSTOP_FAULT;
			default: par_mapped = {13'h0000, par_wdata};
		endcase
	end

	// reaction code register: object write, parameter write, restore
	// restore happens once, one edge after reset release, so the store
	// contents are never caught by the asynchronous reset itself
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			react_code_reg <= REACT_RESET;
		end else if (!restore_done_reg) begin
			if (nv_valid && code_in_range(nv_code)) begin
				react_code_reg <= nv_code;
			end
		end else if (od_wr_ok) begin
			react_code_reg <= od_wdata;
		end else if (par_wr && (par_wdata <= PAR_QSTOP_FAULT)) begin
			react_code_reg <= par_mapped;
		end
	end

	// restore runs only in the first cycle after release
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			restore_done_reg <= 1'b0;
		end else begin
			restore_done_reg <= 1'b1;
		end
	end

	// parameter values above 5 do not exist
	assign par_reject = par_wr && (par_wdata > PAR_QSTOP_FAULT);

	// a save only stores when the object was written since last save
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			save_pending_reg <= 1'b0;
			nv_wr <= 1'b0;
			nv_wdata <= 16'h0000;
		end else begin
			nv_wr <= save_req && save_pending_reg;
			if (save_req && save_pending_reg) begin
				nv_wdata <= react_code_reg;
			end
			// a write in the save cycle stays pending for the next save
			if (od_wr_ok) begin
				save_pending_reg <= 1'b1;
			end else if (save_req) begin
				save_pending_reg <= 1'b0;
			end
		end
	end

	// object dictionary answer, one cycle after the request
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			od_ack <= 1'b0;
			od_abort <= 1'b0;
			od_rdata <= 16'h0000;
		end else begin
			od_ack <= od_req;
			od_abort <= 1'b0;
			if (od_req) begin
				if (od_wr) begin
					// fault code object is read-only; unknown index aborts
					od_abort <= !od_wr_ok;
					od_rdata <= 16'h0000;
				end else if (od_hit_react) begin
					od_rdata <= react_code_reg;
				end else if (od_hit_fault) begin
					od_rdata <= last_fault_code_reg;
				end else begin
					od_abort <= 1'b1;
					od_rdata <= 16'h0000;
				end
			end
		end
	end

	// reaction sequencer; contact control and code 0 never leave idle
	always_comb begin
		state_next = state_reg;
		cmd_next = 4'h0;
		case (state_reg)
			BLR_ST_IDLE: begin
				if (bus_loss && remote_ctrl) begin
					case (react_code_reg)
						REACT_FAULT: begin
							cmd_next = 4'h8;
							state_next = BLR_ST_TRIPPED;
						end
						REACT_SWITCH_OFF: begin
							cmd_next = 4'h4;
						end
						REACT_QUICK_STOP: begin
							cmd_next = 4'h2;
						end
						REACT_RAMP_FAULT: begin
							cmd_next = 4'h1;
							state_next = BLR_ST_STOPPING;
						end
						REACT_QSTOP_FAULT: begin
							cmd_next = 4'h2;
							state_next = BLR_ST_STOPPING;
						end
						default: begin
							cmd_next = 4'h0;
						end
					endcase
				end
			end
			BLR_ST_STOPPING: begin
				// fault only once the drive has stopped
				if (drive_standstill) begin
					cmd_next = 4'h8;
					state_next = BLR_ST_TRIPPED;
				end
			end
			BLR_ST_TRIPPED: begin
				// stays tripped until an accepted fault reset
				if (fault_reset_ok) begin
					state_next = BLR_ST_IDLE;
				end
			end
			default: begin
				state_next = BLR_ST_IDLE;
			end
		endcase
	end

	// sequencer state and registered one-cycle commands
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= BLR_ST_IDLE;
			cmd_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
		end
	end
	assign cmd_fault = cmd_reg[3];
	assign cmd_disable_voltage = cmd_reg[2];
	assign cmd_quick_stop = cmd_reg[1];
	assign cmd_disable_operation = cmd_reg[0];

	// recovery conditions; a new loss in the clearing cycle wins
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			nmt_lost_reg <= 1'b0;
			guard_lost_reg <= 1'b0;
		end else begin
			if (ev_nmt_left_op) begin
				nmt_lost_reg <= 1'b1;
			end else if (nmt_operational) begin
				nmt_lost_reg <= 1'b0;
			end
			if (ev_guard_fail) begin
				guard_lost_reg <= 1'b1;
			end else if (guarding_active) begin
				guard_lost_reg <= 1'b0;
			end
		end
	end

	// reset is combinational so the drive sees the grant with its request
	assign fault_reset_ok = fault_reset_req && nmt_operational
		&& !nmt_lost_reg && !guard_lost_reg;

	// rxpdo discard: only a correctly sized frame reopens the gate
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxpdo_block_reg <= 1'b0;
		end else if (ev_rxpdo_len_err) begin
			rxpdo_block_reg <= 1'b1;
		end else if (rxpdo_valid && rxpdo_len_ok) begin
			rxpdo_block_reg <= 1'b0;
		end
	end
	assign rxpdo_accept = rxpdo_valid && rxpdo_len_ok && !ev_rxpdo_len_err;
	assign rxpdo_blocked = rxpdo_block_reg;

	// fault latch: object, internal code and emergency payload together
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			last_fault_code_reg <= PCODE_NONE;
			current_error_reg <= 16'h0000;
			emcy_valid <= 1'b0;
			emcy_data <= 64'h0000_0000_0000_0000;
		end else begin
			emcy_valid <= fault_valid;
			if (fault_valid) begin
				last_fault_code_reg <= pcode;
				current_error_reg <= fault_code_int;
				emcy_data <= 64'h0000_0000_0000_0000;
				emcy_data[EMCY_PCODE_LSB +: 16] <= pcode;
				emcy_data[EMCY_ICODE_LSB +: 32] <= {16'h0000, fault_code_int};
			end
		end
	end
	assign current_error = current_error_reg;

	// checks
	a_code_range: assert property (@(posedge core_clk) disable iff (!arst_n)
		code_in_range(react_code_reg)) else $error("reaction code out of range");
	a_bad_write_abort: assert property (@(posedge core_clk) disable iff (!arst_n)
		od_req && od_wr && od_hit_react && !code_in_range(od_wdata) && restore_done_reg
		&& !par_wr |=> od_abort && $stable(react_code_reg)) else $error("bad write not aborted");
	a_code1_fault: assert property (@(posedge core_clk) disable iff (!arst_n)
		state_reg == BLR_ST_IDLE && bus_loss && remote_ctrl && react_code_reg == REACT_FAULT
		|=> cmd_fault && state_reg == BLR_ST_TRIPPED) else $error("code 1 did not fault");
	a_code0_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
		state_reg == BLR_ST_IDLE && bus_loss && react_code_reg == REACT_NONE
		|=> cmd_reg == 4'h0) else $error("code 0 reacted");
	a_contact_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
		state_reg == BLR_ST_IDLE && !remote_ctrl |=> cmd_reg == 4'h0) else $error("contact mode reacted");
	a_stop_then_fault: assert property (@(posedge core_clk) disable iff (!arst_n)
		state_reg == BLR_ST_STOPPING && !drive_standstill |=> !cmd_fault) else $error("fault before standstill");
	a_reset_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
		$past(ev_nmt_left_op) |-> !fault_reset_ok) else $error("reset granted after nmt loss");
	a_guard_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
		ev_guard_fail ##1 !guarding_active |-> !fault_reset_ok) else $error("reset without guarding");
	a_pdo_discard: assert property (@(posedge core_clk) disable iff (!arst_n)
		rxpdo_block_reg && !(rxpdo_valid && rxpdo_len_ok) |=> rxpdo_block_reg) else $error("pdo discard ended early");
	a_fault_update: assert property (@(posedge core_clk) disable iff (!arst_n)
		fault_valid |=> last_fault_code_reg == $past(pcode) && emcy_valid
		&& emcy_data[15:0] == last_fault_code_reg) else $error("fault code not latched");

endmodule : blr_bus_loss_reaction

// ### tb/blr_master_model.sv
/*
 * blr_master_model: network master side of the block: object accesses,
 * link status levels and rxpdo frames.
 * assumes: tasks are called by the bench just after a core_clk rising edge.
 */
`timescale 1ns/100ps
module blr_master_model (
	// clock
	input wire logic core_clk,
	// object access
	output logic od_req,
	output logic od_wr,
	output logic [15:0] od_index,
	output logic [15:0] od_wdata,
	input wire logic od_ack,
	input wire logic od_abort,
	input wire logic [15:0] od_rdata,
	// link status
	output logic nmt_operational,
	output logic guarding_active,
	// rxpdo frames
	output logic rxpdo_valid,
	output logic rxpdo_len_ok,
	input wire logic rxpdo_accept
);
	// idle bus, link up
	initial begin
		od_req = 1'b0;
		od_wr = 1'b0;
		od_index = 16'h0000;
		od_wdata = 16'h0000;
		nmt_operational = 1'b1;
		guarding_active = 1'b1;
		rxpdo_valid = 1'b0;
		rxpdo_len_ok = 1'b0;
	end
	// one access: request is a one-cycle pulse, answer taken at the edge where ack is high
	task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
			output logic ab, output logic [15:0] rd);
		int n;
		od_req = 1'b1;
		od_wr = wr;
		od_index = idx;
		od_wdata = wd;
		@(posedge core_clk);
		#1 od_req = 1'b0;
		od_wdata = ~wd; // stale data must not look like a fresh word
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (od_ack !== 1'b1 && n < 4);
		// a missing answer yields unknowns so the caller's compare fails
		ab = (od_ack === 1'b1) ? od_abort : 1'bx;
		rd = (od_ack === 1'b1) ? od_rdata : 16'hXXXX;
		#1;
	endtask : access
	// master drives the node's operational and guarding levels, up or down
	task automatic set_link(input logic op, input logic gd);
		nmt_operational = op;
		guarding_active = gd;
	endtask : set_link
	// one rxpdo frame; a correctly sized one ends the discard phase
	task automatic frame(input logic ok, output logic acc);
		rxpdo_valid = 1'b1;
		rxpdo_len_ok = ok;
		#2 acc = rxpdo_accept;
		@(posedge core_clk);
		#1 rxpdo_valid = 1'b0;
		rxpdo_len_ok = ~ok;
	endtask : frame
endmodule : blr_master_model

// ### tb/tb_blr_bus_loss_reaction.sv
/*
 * tb_blr_bus_loss_reaction: self-checking bench for the reaction block.
 * assumes: design and master model compiled before; 40 MHz core_clk.
 */
`timescale 1ns/100ps
module tb_blr_bus_loss_reaction;
	import blr_pkg::*;
	logic core_clk, arst_n, od_req, od_wr, od_ack, od_abort, par_wr, par_reject, save_req, nv_valid, nv_wr;
	logic [15:0] od_index, od_wdata, od_rdata, nv_code, nv_wdata, fault_code_int, current_error, r;
	logic [2:0] par_wdata;
	logic [5:0] ev; // bus_off, guard, heartbeat, sync, rxpdo length, nmt left
	logic nmt_operational, guarding_active, control_source_setting, drive_standstill, fault_reset_req;
	logic cmd_fault, cmd_disable_voltage, cmd_quick_stop, cmd_disable_operation, fault_reset_ok;
	logic rxpdo_valid, rxpdo_len_ok, rxpdo_accept, rxpdo_blocked, fault_valid, emcy_valid, ab, acc;
	logic [7:0] fault_class;
	logic [63:0] emcy_data;
	int fails, n_checks, cyc;
	// rows: fault class in, profile code out
	logic [7:0] cls_tab [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0D, 8'h09};
	logic [15:0] pc_tab [10] = '{16'h0000, 16'h2310, 16'h4210, 16'h4110, 16'h4310, 16'h2340, 16'h3210,
		16'h5111, 16'h2330, 16'h1000};
	// rows: reaction code in, {fault, disable voltage, quick stop, disable operation} out
	logic [15:0] code_tab [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'hFFFF, 16'hFFFE};
	logic [3:0] cmd_tab [6] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'h2};
	blr_master_model m (.core_clk(core_clk), .od_req(od_req), .od_wr(od_wr), .od_index(od_index),
		.od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort), .od_rdata(od_rdata),
		.nmt_operational(nmt_operational), .guarding_active(guarding_active), .rxpdo_valid(rxpdo_valid),
		.rxpdo_len_ok(rxpdo_len_ok), .rxpdo_accept(rxpdo_accept));
	blr_bus_loss_reaction DUT (.core_clk(core_clk), .arst_n(arst_n), .od_req(od_req), .od_wr(od_wr),
		.od_index(od_index), .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort), .od_rdata(od_rdata),
		.par_wr(par_wr), .par_wdata(par_wdata), .par_reject(par_reject), .save_req(save_req),
		.nv_valid(nv_valid), .nv_code(nv_code), .nv_wr(nv_wr), .nv_wdata(nv_wdata), .ev_bus_off(ev[0]),
		.ev_guard_fail(ev[1]), .ev_heartbeat_fail(ev[2]), .ev_sync_err(ev[3]), .ev_rxpdo_len_err(ev[4]),
		.ev_nmt_left_op(ev[5]), .nmt_operational(nmt_operational), .guarding_active(guarding_active),
		.control_source_setting(control_source_setting), .drive_standstill(drive_standstill),
		.fault_reset_req(fault_reset_req), .cmd_fault(cmd_fault), .cmd_disable_voltage(cmd_disable_voltage),
		.cmd_quick_stop(cmd_quick_stop), .cmd_disable_operation(cmd_disable_operation),
		.fault_reset_ok(fault_reset_ok), .rxpdo_valid(rxpdo_valid), .rxpdo_len_ok(rxpdo_len_ok),
		.rxpdo_accept(rxpdo_accept), .rxpdo_blocked(rxpdo_blocked), .fault_valid(fault_valid),
		.fault_class(fault_class), .fault_code_int(fault_code_int), .current_error(current_error),
		.emcy_valid(emcy_valid), .emcy_data(emcy_data));
	// clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			end_of_test();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask : tick
	// reset held two cycles; restore edge plus one before the first request
	task automatic do_reset;
		arst_n = 1'b0;
		repeat (2) tick();
		arst_n = 1'b1;
		repeat (2) tick();
	endtask : do_reset
	// fault reset: ok is combinational in the request cycle
	task automatic freset(input logic exp);
		fault_reset_req = 1'b1;
		#2 chk(fault_reset_ok, exp);
		tick();
		fault_reset_req = 1'b0;
	endtask : freset
	// set a code, fire event e, check the command pulse, then clear any trip
	task automatic react(input logic [15:0] code, input int e, input logic [3:0] exp);
		m.access(1'b1, OD_IDX_BUS_LOSS_REACTION_SELECT, code, ab, r);
		chk(ab, 1'b0);
		ev[e] = 1'b1;
		tick();
		ev = '0;
		chk({cmd_fault, cmd_disable_voltage, cmd_quick_stop, cmd_disable_operation}, exp);
		if (code[15]) begin
			tick();
			chk(cmd_fault, 1'b0);
			drive_standstill = 1'b1;
			tick();
			chk(cmd_fault, 1'b1);
			drive_standstill = 1'b0;
		end
		tick();
		freset(1'b1);
	endtask : react
	// lost link: fault reset refused until the master restores it
	task automatic gate(input int e, input logic op, input logic gd);
		m.set_link(op, gd);
		ev[e] = 1'b1;
		tick();
		ev = '0;
		tick();
		freset(1'b0);
		m.set_link(1'b1, 1'b1);
		tick();
		freset(1'b1);
	endtask : gate
	initial begin
		{par_wr, par_wdata, save_req, nv_valid, nv_code, ev, drive_standstill} = '0;
		{fault_reset_req, fault_valid, fault_class, fault_code_int} = '0;
		control_source_setting = CTRL_SRC_REMOTE;
		do_reset();
		m.access(1'b0, OD_IDX_BUS_LOSS_REACTION_SELECT, 16'h0000, ab, r);
		chk(r, 16'h0001);
		m.access(1'b0, OD_IDX_LAST_FAULT_CODE, 16'h0000, ab, r);
		chk(r, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			react(code_tab[i], i, cmd_tab[i]);
		end
		for (int i = 0; i < 10; i++) begin
			fault_valid = 1'b1;
			fault_class = cls_tab[i];
			fault_code_int = 16'hA500 | 16'(i);
			tick();
			fault_valid = 1'b0;
			chk(emcy_valid, 1'b1);
			chk(emcy_data, {16'h0000, fault_code_int, 16'h0000, pc_tab[i]});
			chk(current_error, fault_code_int);
			m.access(1'b0, OD_IDX_LAST_FAULT_CODE, 16'h0000, ab, r);
			chk(r, pc_tab[i]);
		end
		control_source_setting = 1'b0;
		react(16'h0001, 0, 4'h0);
		control_source_setting = CTRL_SRC_REMOTE;
		m.access(1'b1, OD_IDX_BUS_LOSS_REACTION_SELECT, 16'h0004, ab, r);
		chk(ab, 1'b1);
		m.access(1'b1, OD_IDX_BUS_LOSS_REACTION_SELECT, 16'hFFFD, ab, r);
		chk(ab, 1'b1);
		m.access(1'b1, OD_IDX_LAST_FAULT_CODE, 16'h0001, ab, r);
		chk(ab, 1'b1);
		m.access(1'b0, OD_IDX_BUS_LOSS_REACTION_SELECT, 16'h0000, ab, r);
		chk(r, 16'h0001);
		par_wr = 1'b1;
		par_wdata = PAR_QSTOP_FAULT;
		tick();
		par_wdata = 3'h6;
		#2 chk(par_reject, 1'b1);
		tick();
		par_wr = 1'b0;
		m.access(1'b0, OD_IDX_BUS_LOSS_REACTION_SELECT, 16'h0000, ab, r);
		chk(r, 16'hFFFE);
		m.access(1'b1, OD_IDX_BUS_LOSS_REACTION_SELECT, 16'h0002, ab, r);
		save_req = 1'b1; // held: the second save finds nothing pending
		for (int i = 0; i < 2; i++) begin
			tick();
			chk({nv_wr, nv_wdata}, {!i[0], 16'h0002});
		end
		save_req = 1'b0;
		gate(5, 1'b0, 1'b1);
		gate(1, 1'b1, 1'b0);
		ev[4] = 1'b1;
		tick();
		ev = '0;
		chk(rxpdo_blocked, 1'b1);
		m.frame(1'b0, acc);
		chk({acc, rxpdo_blocked}, 2'b01);
		tick();
		m.frame(1'b1, acc);
		chk({acc, rxpdo_blocked}, 2'b10);
		nv_valid = 1'b1;
		nv_code = 16'hFFFF;
		do_reset();
		m.access(1'b0, OD_IDX_BUS_LOSS_REACTION_SELECT, 16'h0000, ab, r);
		chk(r, 16'hFFFF);
		m.access(1'b0, OD_IDX_LAST_FAULT_CODE, 16'h0000, ab, r);
		chk(r, 16'h0000);
		end_of_test();
	end
endmodule : tb_blr_bus_loss_reaction
